// File: rtl/acs_sequencer.sv
/*
 * apb slave and sequencer for a 10-bit successive-approximation converter.
 * assumes the comparator settles within one pclk of a dac_code change, an
 * asynchronous rc oscillator pin and a same-clock sleep level from the cpu.
 */
// Our own choice: register access over APB.
// What this block does
// - setting the go bit with the converter on, and not in sleep on a non-rc clock, starts a conversion of the selected channel.
// - interrupt uses flag bit 6, enable bit 6, peripheral and global enables.
// - at least two bit periods pass before the next acquisition.
// - the result has 1024 steps, ten bits.
// - with rc clock the start waits one instruction cycle after go.
// - completion clears go and loads the result pair, also in sleep.
// - enabled completion in sleep wakes; global enable selects the vector.
// - disabled completion in sleep powers the converter down, power bit kept.
// - sleep with a non-rc clock aborts a running conversion and powers down, power bit kept; idle or gap is left as it is.
// - reset restores registers, powers off, aborts; results are kept.
// - the hold capacitor is never discharged between conversions.
// - clock select picks fosc/2,/8,/32,rc,/4,/16,/64.
`timescale 1ns/10ps

module acs_sequencer
	import acs_pkg::*;
#(
	parameter int INSTR_CYCLES = PCLK_PER_INSTR
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sleep_active,
	input wire logic rc_osc_pin,
	input wire logic comparator_pin,
	output logic converter_enable,
	output logic [2:0] channel_select,
	output logic [1:0] vref_select,
	output logic [7:0] analog_pin_select,
	output logic track_enable,
	output logic [9:0] dac_code,
	output logic irq,
	output logic wake_req,
	output logic wake_to_vector
);

	initial
	begin
		if (INSTR_CYCLES < 1 || INSTR_CYCLES > 15)
			$error("INSTR_CYCLES out of range");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	acs_state_t st_q;
	logic go_q, power_on_q, justify_q, pd_q, flag_q;
	logic [2:0] chan_q, clksel_q;
	logic [1:0] vref_q;
	logic [7:0] analog_pin_select_q, pie_q, interrupt_control_q;
	logic [7:0] res_hi_q, res_lo_q;
	logic [9:0] sar_q;
	logic [3:0] bit_q, wait_q;
	logic [6:0] div_q;
	logic [1:0] gap_q;
	logic rc_s1_q, rc_s2_q, rc_s3_q;

	// clock select decode, divide in pclk cycles
	function automatic logic [6:0] tad_div(input logic [2:0] sel);
		unique case (sel)
			3'h0: tad_div = 7'h02;
			3'h1: tad_div = 7'h08;
			3'h2: tad_div = 7'h20;
			3'h4: tad_div = 7'h04;
			3'h5: tad_div = 7'h10;
			3'h6: tad_div = 7'h40;
			default: tad_div = 7'h02;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	logic wr, rd_hit;
	logic [7:0] idx;
	logic [7:0] wdat;
	assign idx = paddr[9:2];
	assign wdat = pwdata[7:0];
	assign wr = psel && penable && pwrite && pstrb[0];
	assign pready = 1'b1;

	always_comb
	begin
		rd_hit = 1'b1;
		prdata = 32'h0000_0000;
		unique case (idx)
			IDX_INTERRUPT_CONTROL: prdata[7:0] = interrupt_control_q;
			IDX_PERIPHERAL_FLAGS_1: prdata[CONV_FLAG_BIT] = flag_q;
			IDX_RESULT_HIGH: prdata[7:0] = res_hi_q;
			IDX_CONVERTER_CONTROL_0: prdata[7:0] = {justify_q, vref_q, chan_q, go_q, power_on_q};
			IDX_PERIPHERAL_ENABLES_1: prdata[7:0] = pie_q;
			IDX_ANALOG_PIN_SELECT: prdata[7:0] = analog_pin_select_q;
			IDX_RESULT_LOW: prdata[7:0] = res_lo_q;
			IDX_CONVERTER_CONTROL_1: prdata[7:0] = {1'b0, clksel_q, 4'h0};
			default: rd_hit = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !rd_hit;

	// ----------------------------------------------------------------
	// synchronisers and conversion clock
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rc_s1_q <= 1'b0;
			rc_s2_q <= 1'b0;
			rc_s3_q <= 1'b0;
		end
		else
		begin
			rc_s1_q <= rc_osc_pin;
			rc_s2_q <= rc_s1_q;
			rc_s3_q <= rc_s2_q;
		end
	end
	// comparator answers our own dac_code within a cycle, so it is read directly;
	// a two-stage sync would feed stale decisions to the sar at the /2 clock

	logic rc_sel, tad_tick, timed;
	assign rc_sel = (clksel_q[1:0] == 2'b11);
	assign timed = (st_q == ACS_SAMPLE) || (st_q == ACS_CONVERT) || (st_q == ACS_GAP);
	assign tad_tick = timed && (rc_sel ? (rc_s2_q && !rc_s3_q)
		: (div_q == tad_div(clksel_q) - 7'h01));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_q <= 7'h00;
		else if (!timed || tad_tick)
			div_q <= 7'h00;
		else
			div_q <= div_q + 7'h01;
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	logic go_wr, start_ok, abort, complete;
	logic [9:0] final_res;
	assign go_wr = wr && (idx == IDX_CONVERTER_CONTROL_0) && wdat[CC0_GO_BIT];
	assign abort = sleep_active && !rc_sel && (st_q != ACS_IDLE) && (st_q != ACS_GAP);
	assign start_ok = go_q && power_on_q && !pd_q && !(sleep_active && !rc_sel);
	assign complete = (st_q == ACS_CONVERT) && tad_tick && (bit_q == 4'h0);
	always_comb
	begin
		final_res = sar_q;
		final_res[0] = comparator_pin;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q <= ACS_IDLE;
			wait_q <= 4'h0;
			bit_q <= 4'h0;
			gap_q <= 2'h0;
			sar_q <= 10'h000;
		end
		else if (abort)
			st_q <= ACS_IDLE;
		else
		begin
			unique case (st_q)
				ACS_IDLE:
				begin
					wait_q <= 4'h0;
					if (start_ok)
						st_q <= rc_sel ? ACS_RC_WAIT : ACS_SAMPLE;
				end
				ACS_RC_WAIT:
				begin
					wait_q <= wait_q + 4'h1;
					if (wait_q == 4'(INSTR_CYCLES - 1))
						st_q <= ACS_SAMPLE;
				end
				ACS_SAMPLE:
				begin
					if (tad_tick)
					begin
						st_q <= ACS_CONVERT;
						bit_q <= SAR_FIRST_BIT;
						sar_q <= 10'h200;
					end
				end
				ACS_CONVERT:
				begin
					if (tad_tick)
					begin
						sar_q[bit_q] <= comparator_pin;
						if (bit_q != 4'h0)
						begin
							sar_q[bit_q - 4'h1] <= 1'b1;
							bit_q <= bit_q - 4'h1;
						end
						else
						begin
							st_q <= ACS_GAP;
							gap_q <= 2'h0;
						end
					end
				end
				ACS_GAP:
				begin
					if (tad_tick)
					begin
						gap_q <= gap_q + 2'h1;
						if (gap_q == 2'(GAP_TADS - 1))
							st_q <= ACS_IDLE;
					end
				end
			endcase
		end
	end

	// track while powered and not converting; the hold capacitor is never shorted
	assign track_enable = converter_enable && (st_q != ACS_CONVERT);
	assign dac_code = sar_q;

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			go_q <= RST_CONVERTER_CONTROL_0[CC0_GO_BIT];
			power_on_q <= RST_CONVERTER_CONTROL_0[CC0_POWER_ON_BIT];
			chan_q <= RST_CONVERTER_CONTROL_0[4:2];
			vref_q <= RST_CONVERTER_CONTROL_0[6:5];
			justify_q <= RST_CONVERTER_CONTROL_0[CC0_JUSTIFY_BIT];
			clksel_q <= RST_CLKSEL;
			analog_pin_select_q <= RST_ANALOG_PIN_SELECT;
			pie_q <= RST_PERIPHERAL_ENABLES_1;
			interrupt_control_q <= RST_INTERRUPT_CONTROL;
		end
		else
		begin
			if (go_wr)
				go_q <= 1'b1;
			else if (complete || abort)
				go_q <= 1'b0;
			if (wr && idx == IDX_CONVERTER_CONTROL_0)
			begin
				power_on_q <= wdat[CC0_POWER_ON_BIT];
				chan_q <= wdat[CC0_CHAN_LSB +: 3];
				vref_q <= wdat[CC0_VREF_LSB +: 2];
				justify_q <= wdat[CC0_JUSTIFY_BIT];
			end
			if (wr && idx == IDX_CONVERTER_CONTROL_1)
				clksel_q <= wdat[CC1_CLKSEL_LSB +: 3];
			if (wr && idx == IDX_ANALOG_PIN_SELECT)
				analog_pin_select_q <= wdat;
			if (wr && idx == IDX_PERIPHERAL_ENABLES_1)
				pie_q <= wdat;
			if (wr && idx == IDX_INTERRUPT_CONTROL)
				interrupt_control_q <= wdat;
		end
	end

	// power-down latch: kept until sleep ends, power bit untouched
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pd_q <= 1'b0;
		else if (abort)
			pd_q <= 1'b1;
		else if (complete && sleep_active && !pie_q[CONV_ENABLE_BIT])
			pd_q <= 1'b1;
		else if (!sleep_active)
			pd_q <= 1'b0;
	end

	// results have no reset so they survive it
	always_ff @(posedge pclk)
	begin
		if (complete)
		begin
			if (justify_q)
			begin
				res_hi_q <= {6'h00, final_res[9:8]};
				res_lo_q <= final_res[7:0];
			end
			else
			begin
				res_hi_q <= final_res[9:2];
				res_lo_q <= {final_res[1:0], 6'h00};
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupt
	// ----------------------------------------------------------------
	logic flag_clr;
	assign flag_clr = wr && (idx == IDX_PERIPHERAL_FLAGS_1) && wdat[CONV_FLAG_BIT];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flag_q <= 1'b0;
		else if (complete)
			flag_q <= 1'b1;
		else if (flag_clr)
			flag_q <= 1'b0;
	end

	assign irq = flag_q && pie_q[CONV_ENABLE_BIT] && interrupt_control_q[PERIPH_IRQ_EN_BIT]
		&& interrupt_control_q[GLOBAL_IRQ_EN_BIT];
	assign wake_req = sleep_active && flag_q && pie_q[CONV_ENABLE_BIT];
	assign wake_to_vector = wake_req && interrupt_control_q[GLOBAL_IRQ_EN_BIT];
	assign converter_enable = power_on_q && !pd_q;
	assign channel_select = chan_q;
	assign vref_select = vref_q;
	assign analog_pin_select = analog_pin_select_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_go_done_clear: assert property (complete && !go_wr |=> !go_q && flag_q)
		else $error("go not cleared at completion");
	chk_start_go: assert property (st_q == ACS_IDLE && start_ok && !abort
		|=> st_q != ACS_IDLE)
		else $error("go did not start a conversion");
	chk_rc_delay: assert property (st_q == ACS_IDLE && start_ok && rc_sel && !abort
		|=> (st_q == ACS_RC_WAIT) [*4])
		else $error("rc start not delayed");
	chk_gap_hold: assert property (st_q == ACS_GAP && !(tad_tick && gap_q == 2'h1)
		|=> st_q == ACS_GAP)
		else $error("gap ended early");
	chk_abort_sleep: assert property (abort |=> st_q == ACS_IDLE && !go_q && pd_q
		&& power_on_q == $past(power_on_q))
		else $error("sleep abort wrong");
	chk_sleep_pd: assert property (complete && sleep_active && !pie_q[CONV_ENABLE_BIT]
		|=> pd_q && !converter_enable)
		else $error("converter not powered down");
	chk_sleep_wake: assert property (complete && sleep_active && pie_q[CONV_ENABLE_BIT]
		&& !flag_clr ##1 sleep_active |-> wake_req)
		else $error("no wake on completion");
	chk_flag_sticky: assert property (flag_q && !flag_clr |=> flag_q)
		else $error("flag lost");
	chk_left_justify: assert property (complete && !justify_q
		|=> res_hi_q == $past(final_res[9:2]))
		else $error("left justify wrong");
	chk_bit_walk: assert property (st_q == ACS_CONVERT && tad_tick && bit_q != 4'h0 && !abort
		|=> bit_q == $past(bit_q) - 4'h1)
		else $error("sar bit order wrong");

	cov_conversion: cover property (complete ##[1:200] st_q == ACS_IDLE);
	cov_rc_sleep: cover property (complete && sleep_active && rc_sel);
	cov_abort: cover property (abort);
	cov_flag_clear: cover property (flag_q ##1 flag_clr ##1 !flag_q);

endmodule

// File: rtl/acs_pkg.sv
/*
 * constants of the converter sequencer: register indices, field positions,
 * reset values and timing counts.
 * assumes a 10 MHz pclk and a 32-bit apb bus where byte address = 4 * index.
 */
package acs_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0b;
	localparam logic [7:0] IDX_PERIPHERAL_FLAGS_1 = 8'h0c;
	localparam logic [7:0] IDX_RESULT_HIGH = 8'h1e;
	localparam logic [7:0] IDX_CONVERTER_CONTROL_0 = 8'h1f;
	localparam logic [7:0] IDX_PERIPHERAL_ENABLES_1 = 8'h8c;
	localparam logic [7:0] IDX_ANALOG_PIN_SELECT = 8'h91;
	localparam logic [7:0] IDX_RESULT_LOW = 8'h9e;
	localparam logic [7:0] IDX_CONVERTER_CONTROL_1 = 8'h9f;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CC0_POWER_ON_BIT = 0;
	localparam int CC0_GO_BIT = 1;
	localparam int CC0_CHAN_LSB = 2;
	localparam int CC0_VREF_LSB = 5;
	localparam int CC0_JUSTIFY_BIT = 7;
	localparam int CC1_CLKSEL_LSB = 4;
	localparam int CONV_FLAG_BIT = 6;
	localparam int CONV_ENABLE_BIT = 6;
	localparam int PERIPH_IRQ_EN_BIT = 6;
	localparam int GLOBAL_IRQ_EN_BIT = 7;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
	localparam logic [7:0] RST_PERIPHERAL_ENABLES_1 = 8'h00;
	localparam logic [7:0] RST_ANALOG_PIN_SELECT = 8'hff;
	localparam logic [7:0] RST_CONVERTER_CONTROL_0 = 8'h00;
	localparam logic [2:0] RST_CLKSEL = 3'h0;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int RESULT_BITS = 10;
	localparam int GAP_TADS = 2;
	localparam int PCLK_PER_INSTR = 4;
	localparam logic [3:0] SAR_FIRST_BIT = 4'h9;

	typedef enum logic [4:0] {
		ACS_IDLE = 5'b00001,
		ACS_RC_WAIT = 5'b00010,
		ACS_SAMPLE = 5'b00100,
		ACS_CONVERT = 5'b01000,
		ACS_GAP = 5'b10000
	} acs_state_t;

endpackage

// File: test/acs_analog_model.sv
/*
 * behavioural analog core: a 1024-step comparator against a level set by the
 * bench, and a free-running rc oscillator.
 * assumes dac_code and converter_enable come from the sequencer.
 */
`timescale 1ns/10ps

module acs_analog_model
(
	input wire logic rc_run,
	input wire logic [9:0] level,
	input wire logic converter_enable,
	input wire logic [9:0] dac_code,
	output logic comparator_pin,
	output logic rc_osc_pin
);
	initial
	begin
		comparator_pin = 1'b0;
		rc_osc_pin = 1'b0;
	end

	// ----------------------------------------------------------------
	// comparator
	// ----------------------------------------------------------------
	// held sample keeps its charge, so the level stays valid between conversions
	always @(level, dac_code, converter_enable)
		if (converter_enable)
			comparator_pin = (level >= dac_code);

	// powered down: output wanders so nothing can rely on it
	always #37
		if (!converter_enable)
			comparator_pin = ~comparator_pin;

	// ----------------------------------------------------------------
	// rc oscillator, unrelated to pclk
	// ----------------------------------------------------------------
	always #730
		if (rc_run)
			rc_osc_pin = ~rc_osc_pin;
endmodule

// File: test/testbench.sv
/*
 * self-checking bench of the converter sequencer.
 * assumes acs_pkg, the sequencer and the analog model are compiled first.
 */
`timescale 1ns/10ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin miscompares++; \
	$display("ERROR %s expected %h seen %h", n, e, a); end end

module testbench;
	import acs_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic sleep_active = 0, rc_run = 0, pready, pslverr, rc_osc_pin, comparator_pin;
	logic converter_enable, track_enable, irq, wake_req, wake_to_vector;
	logic [9:0] paddr = 0, level = 0, dac_code;
	logic [31:0] pwdata = 0, prdata;
	logic [3:0] pstrb = 0;
	logic [2:0] channel_select;
	logic [1:0] vref_select;
	logic [7:0] analog_pin_select;
	int miscompares = 0, checked = 0, cycles = 0;

	acs_sequencer #(.INSTR_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_active(sleep_active),
		.rc_osc_pin(rc_osc_pin), .comparator_pin(comparator_pin),
		.converter_enable(converter_enable), .channel_select(channel_select),
		.vref_select(vref_select), .analog_pin_select(analog_pin_select),
		.track_enable(track_enable), .dac_code(dac_code), .irq(irq), .wake_req(wake_req),
		.wake_to_vector(wake_to_vector));

	acs_analog_model MODEL (.rc_run(rc_run), .level(level), .converter_enable(converter_enable),
		.dac_code(dac_code), .comparator_pin(comparator_pin), .rc_osc_pin(rc_osc_pin));

	always #50 pclk = ~pclk;

	// ----------------------------------------------------------------
	// timeout
	// ----------------------------------------------------------------
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles > 60000)
		begin
			miscompares++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (miscompares == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// apb master
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [7:0] rdv, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		pstrb <= 4'hf;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rdv = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		logic [7:0] d;
		logic e;
		apb(1'b1, idx, wd, d, e);
	endtask

	task automatic rd(input logic [7:0] idx, output logic [7:0] d);
		logic e;
		apb(1'b0, idx, 8'h00, d, e);
	endtask

	task automatic wait_for(ref logic s, input logic v);
		int n;
		n = 0;
		do
		begin
			@(posedge pclk);
			#1;
			n++;
		end
		while (s !== v && n < 3000);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic check_reset();
		logic [7:0] idx [7] = '{IDX_INTERRUPT_CONTROL, IDX_PERIPHERAL_FLAGS_1,
			IDX_CONVERTER_CONTROL_0, IDX_PERIPHERAL_ENABLES_1, IDX_ANALOG_PIN_SELECT,
			IDX_CONVERTER_CONTROL_1, 8'h20};
		logic [7:0] exp [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
		logic [7:0] d;
		logic e;
		for (int i = 0; i < 7; i++)
		begin
			apb(1'b0, idx[i], 8'h00, d, e);
			`CHK("reset value", exp[i], d)
			`CHK("slave error", (i == 6), e)
		end
		`CHK("pin select port", 8'hff, analog_pin_select)
	endtask

	task automatic convert(input logic [2:0] sel, input int div, input logic [9:0] val);
		logic [7:0] h, l;
		int n;
		level = val;
		wr(IDX_CONVERTER_CONTROL_1, {1'b0, sel, 4'h0});
		wr(IDX_CONVERTER_CONTROL_0, {sel[0], 7'h01});
		repeat (50)
			@(posedge pclk);
		wr(IDX_CONVERTER_CONTROL_0, {sel[0], 7'h03});
		n = 0;
		do
		begin
			@(posedge pclk);
			#1;
			n++;
		end
		while (irq !== 1'b1 && n < 3000);
		if (sel[1:0] != 2'b11)
			`CHK("conversion cycles", 11 * div + 1, n)
		`CHK("irq on completion", 1'b1, irq)
		rd(IDX_CONVERTER_CONTROL_0, h);
		`CHK("go after completion", 1'b0, h[1])
		rd(IDX_RESULT_HIGH, h);
		rd(IDX_RESULT_LOW, l);
		`CHK("result pair", sel[0] ? {6'h0, val} : {val, 6'h0}, {h, l})
		wr(IDX_PERIPHERAL_FLAGS_1, 8'h40);
		#1;
		`CHK("irq after clear", 1'b0, irq)
		repeat (2 * div)
			@(posedge pclk);
	endtask

	task automatic check_conversions();
		int div [8] = '{2, 8, 32, 20, 4, 16, 64, 20};
		rc_run = 1'b1;
		wr(IDX_PERIPHERAL_ENABLES_1, 8'h40);
		wr(IDX_INTERRUPT_CONTROL, 8'hc0);
		for (int s = 0; s < 8; s++)
			convert(s[2:0], div[s], 10'h2a5 ^ {s[2:0], 7'h15});
	endtask

	task automatic check_sleep_abort();
		logic [7:0] d;
		wr(IDX_CONVERTER_CONTROL_1, 8'h10);
		wr(IDX_CONVERTER_CONTROL_0, 8'h03);
		repeat (20)
			@(posedge pclk);
		sleep_active <= 1'b1;
		repeat (3)
			@(posedge pclk);
		#1;
		`CHK("powered down in sleep", 1'b0, converter_enable)
		`CHK("no tracking in sleep", 1'b0, track_enable)
		rd(IDX_CONVERTER_CONTROL_0, d);
		`CHK("control after abort", 8'h01, d)
		rd(IDX_PERIPHERAL_FLAGS_1, d);
		`CHK("flag after abort", 8'h00, d)
		sleep_active <= 1'b0;
		repeat (2)
			@(posedge pclk);
		#1;
		`CHK("power after wake", 1'b1, converter_enable)
	endtask

	task automatic check_sleep_rc();
		logic [7:0] d;
		wr(IDX_INTERRUPT_CONTROL, 8'h40);
		wr(IDX_CONVERTER_CONTROL_1, 8'h30);
		wr(IDX_CONVERTER_CONTROL_0, 8'h03);
		sleep_active <= 1'b1;
		wait_for(wake_req, 1'b1);
		`CHK("wake", 1'b1, wake_req)
		`CHK("vector without global", 1'b0, wake_to_vector)
		rd(IDX_CONVERTER_CONTROL_0, d);
		`CHK("go after sleep run", 8'h01, d)
		wr(IDX_INTERRUPT_CONTROL, 8'hc0);
		#1;
		`CHK("vector with global", 1'b1, wake_to_vector)
		sleep_active <= 1'b0;
		wr(IDX_PERIPHERAL_FLAGS_1, 8'h40);
		wr(IDX_PERIPHERAL_ENABLES_1, 8'h00);
		repeat (40)
			@(posedge pclk);
		wr(IDX_CONVERTER_CONTROL_0, 8'h03);
		sleep_active <= 1'b1;
		wait_for(converter_enable, 1'b0);
		`CHK("powered down after run", 1'b0, converter_enable)
		`CHK("no wake", 1'b0, wake_req)
		rd(IDX_CONVERTER_CONTROL_0, d);
		`CHK("power bit kept", 8'h01, d)
		sleep_active <= 1'b0;
	endtask

	task automatic check_ports();
		wr(IDX_ANALOG_PIN_SELECT, 8'h0f);
		wr(IDX_CONVERTER_CONTROL_0, 8'h75);
		#1;
		`CHK("pin select written", 8'h0f, analog_pin_select)
		`CHK("channel port", 3'h5, channel_select)
		`CHK("reference port", 2'h3, vref_select)
		`CHK("tracking while idle", 1'b1, track_enable)
	endtask

	task automatic check_mid_reset();
		logic [7:0] h, l, d;
		rd(IDX_RESULT_HIGH, h);
		rd(IDX_RESULT_LOW, l);
		level = ~level;
		repeat (40)
			@(posedge pclk);
		wr(IDX_CONVERTER_CONTROL_0, 8'h03);
		repeat (10)
			@(posedge pclk);
		presetn <= 1'b0;
		repeat (2)
			@(posedge pclk);
		presetn <= 1'b1;
		#1;
		`CHK("power after reset", 1'b0, converter_enable)
		`CHK("trial code after reset", 10'h000, dac_code)
		rd(IDX_CONVERTER_CONTROL_0, d);
		`CHK("control after reset", 8'h00, d)
		rd(IDX_RESULT_HIGH, d);
		`CHK("high kept", h, d)
		rd(IDX_RESULT_LOW, d);
		`CHK("low kept", l, d)
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (10)
			@(posedge pclk);
		presetn <= 1'b1;
		check_reset();
		check_conversions();
		check_sleep_abort();
		check_sleep_rc();
		check_ports();
		check_mid_reset();
		finish_test();
	end
endmodule
